// ---- verilog/eeprom_wr_pkg.sv ----
// Shared constants and types for the serial EEPROM write path
package eeprom_wr_pkg;
	// Control code value is a plain default, not taken from any part
	localparam logic [3:0] CTRL_CODE = 4'hA;
	localparam int ADDR_W = 17;
	localparam int PAGE_W = 7;
	localparam int PAGE_BYTES = 128;
	localparam int BASE_W = ADDR_W - PAGE_W;
	localparam int CLK_HZ = 25_000_000;
	localparam int TWC_MS = 5;
	// Longest time: rounds down
	localparam int TWC_CYCLES = (CLK_HZ / 1000) * TWC_MS;
	localparam logic [3:0] BIT_LAST = 4'h8;
	localparam logic [8:0] STEP_END = 9'h100;
	localparam logic [1:0] IDX_CTRL = 2'h0;
	localparam logic [1:0] IDX_HI = 2'h1;
	localparam logic [1:0] IDX_LO = 2'h2;
	localparam logic [1:0] IDX_DATA = 2'h3;
	// Control byte field positions
	localparam int CB_CS_HI = 3;
	localparam int CB_CS_LO = 2;
	localparam int CB_BLOCK = 1;
	localparam int CB_RW = 0;
	typedef enum logic [3:0] {
		ST_IDLE = 4'h1,
		ST_RECV = 4'h2,
		ST_ACK = 4'h4,
		ST_SKIP = 4'h8
	} bus_state_type;
endpackage

// ---- verilog/page_buffer.sv ----
// Page buffer: 128 bytes, one write port, one registered read port
`timescale 1ns/1ps
`default_nettype none
module page_buffer (
	input wire logic mclk_i,
	input wire logic rst_i,
	input wire logic we_i,
	input wire logic [eeprom_wr_pkg::PAGE_W-1:0] waddr_i,
	input wire logic [7:0] wdata_i,
	input wire logic [eeprom_wr_pkg::PAGE_W-1:0] raddr_i,
	output logic [7:0] rdata_o
);
	import eeprom_wr_pkg::*;

	logic [7:0] mem [PAGE_BYTES];

	// Storage carries no reset; validity is tracked by the owner
	always_ff @(posedge mclk_i) begin
		if (we_i) begin
			mem[waddr_i] <= wdata_i;
		end
	end

	always_ff @(posedge mclk_i or posedge rst_i) begin
		if (rst_i) begin
			rdata_o <= 8'h00;
		end else begin
			rdata_o <= mem[raddr_i];
		end
	end
endmodule
`default_nettype wire

// ---- verilog/serial_eeprom_write_path.sv ----
// Write path of a two-wire serial EEPROM slave
// Functional notes
// - Acknowledge a matching write control byte on its ninth clock.
// - First address byte loads pointer high part, second the low part; both acked.
// - Data byte is acked; Stop then launches the timed write cycle.
// - During the write cycle, nack a control byte equal to the launching one.
// - Under write protect ack everything but write nothing, stay ready.
// - After a byte write the pointer holds the next address.
// - The whole page is rewritten, unchanged bytes included.
// - Up to 127 more data bytes are buffered and committed after Stop.
// - Each data byte increments only the low seven pointer bits.
// - Beyond 128 bytes the counter rolls and overwrites buffered bytes.
// - Write protect high guards the whole array; low disables guard.
// - Write protect is sampled at Stop; later changes are ignored.
// - Writes reaching a page end wrap to the same page start.
// - After the cycle ends, the polling control byte is acked.
// - Data changes only while clock low; changes while high mark Start/Stop.
// - Respond only when chip-select bits match the chip-select inputs.
// - The write cycle lasts at most 5 ms.
`timescale 1ns/1ps
`default_nettype none
module serial_eeprom_write_path #(
	parameter int TWC_CYCLES_P = eeprom_wr_pkg::TWC_CYCLES
) (
	input wire logic mclk_i,
	input wire logic rst_i,
	input wire logic scl_i,
	input wire logic sda_i,
	output logic sda_o,
	output logic sda_oe_o,
	input wire logic write_protect_i,
	input wire logic chip_select_input_low_i,
	input wire logic chip_select_input_high_i,
	output logic busy_o,
	output logic [eeprom_wr_pkg::ADDR_W-1:0] addr_ptr_o,
	output logic [eeprom_wr_pkg::ADDR_W-1:0] mem_addr_o,
	output logic mem_we_o,
	output logic [7:0] mem_wdata_o,
	input wire logic [7:0] mem_rdata_i
);
	import eeprom_wr_pkg::*;

	// ----------------------------------------
	// Pin synchronisers and bus events
	// ----------------------------------------
	logic [4:0] meta_q, sync_q;
	logic [1:0] prev_q;
	always_ff @(posedge mclk_i or posedge rst_i) begin
		if (rst_i) begin
			meta_q <= 5'h18;
			sync_q <= 5'h18;
			prev_q <= 2'h3;
		end else begin
			meta_q <= {scl_i, sda_i, write_protect_i, chip_select_input_high_i,
				chip_select_input_low_i};
			sync_q <= meta_q;
			prev_q <= sync_q[4:3];
		end
	end
	wire scl_s = sync_q[4];
	wire sda_s = sync_q[3];
	wire wp_s = sync_q[2];
	wire cs_hi_s = sync_q[1];
	wire cs_lo_s = sync_q[0];
	wire scl_rise = scl_s & ~prev_q[1];
	wire scl_fall = ~scl_s & prev_q[1];
	// Data edges under a steady high clock are Start and Stop
	wire start_ev = scl_s & prev_q[1] & prev_q[0] & ~sda_s;
	wire stop_ev = scl_s & prev_q[1] & ~prev_q[0] & sda_s;

	// ----------------------------------------
	// State
	// ----------------------------------------
	bus_state_type st_q, st_d;
	logic [3:0] bitcnt_q, bitcnt_d;
	logic [7:0] shreg_q;
	logic [1:0] idx_q;
	logic [ADDR_W-1:0] ptr_q;
	logic [6:0] cur_ctrl_q, launch_q;
	logic [PAGE_BYTES-1:0] valid_q;
	logic have_data_q, busy_q;
	logic [BASE_W-1:0] base_q;
	logic [8:0] step_q;
	logic [16:0] cyc_q;
	logic [7:0] buf_rdata;

	// ----------------------------------------
	// Byte decode
	// ----------------------------------------
	wire byte_done = (st_q == ST_RECV) && (bitcnt_q == BIT_LAST) && scl_fall;
	wire ctrl_match = (shreg_q[7:4] == CTRL_CODE) && (shreg_q[CB_CS_HI] == cs_hi_s)
		&& (shreg_q[CB_CS_LO] == cs_lo_s) && !shreg_q[CB_RW];
	// Acknowledge polling: same control byte as the running write stays silent
	wire poll_block = busy_q && (shreg_q[7:1] == launch_q);
	wire is_ctrl = (idx_q == IDX_CTRL);
	wire ack_ctrl = ctrl_match && !poll_block;
	wire accept = byte_done && (!is_ctrl || ack_ctrl);
	wire ctrl_take = byte_done && is_ctrl && ack_ctrl;
	// Data arriving while the array is busy is acked but dropped
	wire data_take = byte_done && (idx_q == IDX_DATA) && !busy_q;
	wire commit_go = stop_ev && have_data_q && !busy_q && !wp_s;
	wire wp_drop = stop_ev && have_data_q && !busy_q && wp_s;
	wire [6:0] wr_off = step_q[7:1];
	wire stepping = busy_q && (step_q != STEP_END);
	wire cyc_end = busy_q && !stepping && (cyc_q >= 17'(TWC_CYCLES_P - 1));

	always_comb begin
		st_d = st_q;
		bitcnt_d = bitcnt_q;
		if (start_ev) begin
			st_d = ST_RECV;
			bitcnt_d = 4'h0;
		end else if (stop_ev) begin
			st_d = ST_IDLE;
		end else begin
			unique case (st_q)
				ST_IDLE, ST_SKIP: begin
				end
				ST_RECV: begin
					if (scl_rise) begin
						bitcnt_d = bitcnt_q + 4'h1;
					end
					if (byte_done) begin
						st_d = accept ? ST_ACK : ST_SKIP;
					end
				end
				ST_ACK: begin
					if (scl_fall) begin
						st_d = ST_RECV;
						bitcnt_d = 4'h0;
					end
				end
				default: st_d = ST_IDLE;
			endcase
		end
	end

	// ----------------------------------------
	// Bus side registers
	// ----------------------------------------
	always_ff @(posedge mclk_i or posedge rst_i) begin
		if (rst_i) begin
			st_q <= ST_IDLE;
			bitcnt_q <= 4'h0;
			shreg_q <= 8'h00;
			sda_o <= 1'b0;
			sda_oe_o <= 1'b0;
		end else begin
			st_q <= st_d;
			bitcnt_q <= bitcnt_d;
			sda_o <= 1'b0;
			if (st_q == ST_RECV && scl_rise) begin
				shreg_q <= {shreg_q[6:0], sda_s};
			end
			// Pull low through the whole ninth clock, release on its fall
			if (start_ev || stop_ev || (st_q == ST_ACK && scl_fall)) begin
				sda_oe_o <= 1'b0;
			end else if (accept) begin
				sda_oe_o <= 1'b1;
			end
		end
	end

	always_ff @(posedge mclk_i or posedge rst_i) begin
		if (rst_i) begin
			idx_q <= IDX_CTRL;
			ptr_q <= '0;
			cur_ctrl_q <= 7'h00;
			have_data_q <= 1'b0;
		end else begin
			if (start_ev) begin
				idx_q <= IDX_CTRL;
			end else if (accept && idx_q != IDX_DATA) begin
				idx_q <= idx_q + 2'h1;
			end
			if (ctrl_take) begin
				cur_ctrl_q <= shreg_q[7:1];
				ptr_q[ADDR_W-1] <= shreg_q[CB_BLOCK];
			end
			if (accept && idx_q == IDX_HI) begin
				ptr_q[15:8] <= shreg_q;
			end
			if (accept && idx_q == IDX_LO) begin
				ptr_q[7:0] <= shreg_q;
			end
			// Only the in-page part counts, so the page wraps on itself
			if (data_take) begin
				ptr_q[PAGE_W-1:0] <= ptr_q[PAGE_W-1:0] + 7'h01;
			end
			if (start_ev || stop_ev) begin
				have_data_q <= 1'b0;
			end else if (data_take) begin
				have_data_q <= 1'b1;
			end
		end
	end

	page_buffer u_buf (
		.mclk_i(mclk_i),
		.rst_i(rst_i),
		.we_i(data_take),
		.waddr_i(ptr_q[PAGE_W-1:0]),
		.wdata_i(shreg_q),
		.raddr_i(wr_off),
		.rdata_o(buf_rdata)
	);

	// ----------------------------------------
	// Self-timed write cycle
	// ----------------------------------------
	always_ff @(posedge mclk_i or posedge rst_i) begin
		if (rst_i) begin
			valid_q <= '0;
			busy_q <= 1'b0;
			launch_q <= 7'h00;
			base_q <= '0;
			step_q <= 9'h000;
			cyc_q <= 17'h00000;
		end else begin
			// A new command starts from an empty page image
			if ((ctrl_take && !busy_q) || wp_drop || cyc_end) begin
				valid_q <= '0;
			end else if (data_take) begin
				valid_q[ptr_q[PAGE_W-1:0]] <= 1'b1;
			end
			if (commit_go) begin
				busy_q <= 1'b1;
				launch_q <= cur_ctrl_q;
				base_q <= ptr_q[ADDR_W-1:PAGE_W];
				step_q <= 9'h000;
				cyc_q <= 17'h00000;
			end else if (busy_q) begin
				cyc_q <= cyc_q + 17'h00001;
				if (stepping) begin
					step_q <= step_q + 9'h001;
				end
				if (cyc_end) begin
					busy_q <= 1'b0;
				end
			end
		end
	end

	// Two cycles per byte: present address, then write with the merged byte
	always_ff @(posedge mclk_i or posedge rst_i) begin
		if (rst_i) begin
			mem_addr_o <= '0;
			mem_we_o <= 1'b0;
			mem_wdata_o <= 8'h00;
			busy_o <= 1'b0;
			addr_ptr_o <= '0;
		end else begin
			if (stepping && !step_q[0]) begin
				mem_addr_o <= {base_q, wr_off};
			end
			mem_we_o <= stepping && step_q[0];
			mem_wdata_o <= valid_q[wr_off] ? buf_rdata : mem_rdata_i;
			busy_o <= busy_q;
			addr_ptr_o <= ptr_q;
		end
	end

	// ----------------------------------------
	// Assertions
	// ----------------------------------------
	default clocking cb @(posedge mclk_i); endclocking
	default disable iff (rst_i);

	property p_ack_ctrl;
		byte_done && is_ctrl && ctrl_match && !busy_q |=> sda_oe_o;
	endproperty
	a_ack_ctrl: assert property (p_ack_ctrl) else $error("control byte not acked");

	property p_poll_nack;
		byte_done && is_ctrl && poll_block |=> !sda_oe_o && st_q == ST_SKIP;
	endproperty
	a_poll_nack: assert property (p_poll_nack) else $error("acked during write cycle");

	property p_mismatch;
		byte_done && is_ctrl && !ctrl_match |=> !sda_oe_o && $stable(ptr_q);
	endproperty
	a_mismatch: assert property (p_mismatch) else $error("foreign control byte taken");

	property p_wp_block;
		wp_drop |=> !busy_q && valid_q == '0;
	endproperty
	a_wp_block: assert property (p_wp_block) else $error("protected write started");

	property p_launch;
		commit_go |=> busy_q && launch_q == $past(cur_ctrl_q);
	endproperty
	a_launch: assert property (p_launch) else $error("Stop did not launch write");

	property p_inc7;
		data_take |=> ptr_q[ADDR_W-1:PAGE_W] == $past(ptr_q[ADDR_W-1:PAGE_W])
			&& ptr_q[PAGE_W-1:0] == $past(ptr_q[PAGE_W-1:0]) + 7'h01;
	endproperty
	a_inc7: assert property (p_inc7) else $error("pointer increment wrong");

	sequence s_first_writes;
		##2 mem_we_o ##1 !mem_we_o ##1 mem_we_o;
	endsequence
	property p_page_walk;
		commit_go |=> s_first_writes;
	endproperty
	a_page_walk: assert property (p_page_walk) else $error("page rewrite not started");

	property p_twc;
		busy_q |-> cyc_q < 17'(TWC_CYCLES_P);
	endproperty
	a_twc: assert property (p_twc) else $error("write cycle too long");

	property p_wp_held;
		busy_q && $changed(wp_s) |=> busy_q || $past(cyc_end);
	endproperty
	a_wp_held: assert property (p_wp_held) else $error("wp change aborted write");
endmodule
`default_nettype wire

// ---- test/bus_master_model.sv ----
// Two-wire bus master model driving SCL and pulling SDA low
`timescale 1ns/1ps
`default_nettype none
module bus_master_model (
	input wire logic mclk_i,
	input wire logic sda_i,
	output logic scl_o,
	output logic sda_low_o
);
	// ----------------------------------------
	// Bus timing: 8 system cycles per SCL period
	// ----------------------------------------
	initial begin
		scl_o = 1'b1;
		sda_low_o = 1'b0;
	end
	task automatic tick(input int n);
		repeat (n) @(posedge mclk_i);
		#1;
	endtask
	// Long low lead-in lets the slave drop its acknowledge first
	task automatic start_cond;
		sda_low_o = 1'b0;
		tick(4);
		scl_o = 1'b1;
		tick(2);
		sda_low_o = 1'b1;
		tick(2);
		scl_o = 1'b0;
		tick(1);
	endtask
	task automatic stop_cond;
		sda_low_o = 1'b1;
		tick(4);
		scl_o = 1'b1;
		tick(2);
		sda_low_o = 1'b0;
		tick(4);
	endtask
	task automatic xfer(input logic [7:0] b, output logic ack);
		for (int i = 8; i >= 0; i--) begin
			sda_low_o = (i > 0) ? ~b[i-1] : 1'b0;
			tick(3);
			scl_o = 1'b1;
			tick(2);
			if (i == 0) ack = (sda_i === 1'b0);
			tick(2);
			scl_o = 1'b0;
			tick(1);
		end
	endtask
endmodule
`default_nettype wire

// ---- test/serial_eeprom_write_path_bench.sv ----
// Self-checking bench for the EEPROM write path
`timescale 1ns/1ps
`default_nettype none
module serial_eeprom_write_path_bench;
	import eeprom_wr_pkg::*;
	logic mclk = 1'b0, rst = 1'b1, wp = 1'b0, cs_lo = 1'b1, cs_hi = 1'b0;
	logic scl, m_low, sda_oe, sda_dev, busy, mwe, ack;
	logic [16:0] ptr, maddr;
	logic [7:0] mwdata, mrdata;
	// Fixed array: unwritten cells stay unknown, so stray reads show up
	logic [7:0] mem [0:17'h1FFFF];
	int fail_count = 0, n_tests = 0, cyc = 0, nwr = 0;
	wire sda = m_low ? 1'b0 : (sda_oe ? sda_dev : 1'b1);
	// Unwritten array bytes read as a pattern of their address
	assign mrdata = maddr[7:0] ^ 8'h3C;
	initial forever #20 mclk = ~mclk;
	serial_eeprom_write_path #(.TWC_CYCLES_P(400)) i_serial_eeprom_write_path (
		.mclk_i(mclk), .rst_i(rst), .scl_i(scl), .sda_i(sda), .sda_o(sda_dev),
		.sda_oe_o(sda_oe), .write_protect_i(wp), .chip_select_input_low_i(cs_lo),
		.chip_select_input_high_i(cs_hi), .busy_o(busy), .addr_ptr_o(ptr),
		.mem_addr_o(maddr), .mem_we_o(mwe), .mem_wdata_o(mwdata), .mem_rdata_i(mrdata));
	bus_master_model i_bus_master_model (.mclk_i(mclk), .sda_i(sda), .scl_o(scl),
		.sda_low_o(m_low));
	// ----------------------------------------
	// Array model, timeout and checking tasks
	// ----------------------------------------
	always @(posedge mclk) begin
		cyc++;
		if (mwe === 1'b1) begin
			mem[maddr] = mwdata;
			nwr++;
		end
		if (cyc == 30000) begin
			fail_count++;
			results();
		end
	end
	function automatic logic [7:0] getm(input logic [16:0] a);
		return mem[a];
	endfunction
	task automatic check(input logic [31:0] seen, input logic [31:0] exp);
		n_tests++;
		if (seen !== exp) begin
			fail_count++;
			$display("unexpected at %0t: seen %0h expected %0h", $time, seen, exp);
		end
	endtask
	task automatic cmd(input logic [7:0] ctrl, input logic exp_ack);
		i_bus_master_model.start_cond();
		i_bus_master_model.xfer(ctrl, ack);
		check(ack, exp_ack);
	endtask
	task automatic send(input logic [7:0] b);
		i_bus_master_model.xfer(b, ack);
		check(ack, 1'b1);
	endtask
	task automatic wait_busy(input logic lvl);
		int n;
		n = 0;
		while (busy !== lvl && n < 600) begin
			@(posedge mclk);
			n++;
		end
		#1;
		check(busy, lvl);
	endtask
	task automatic results;
		$display("checks %0d, mismatches %0d", n_tests, fail_count);
		if (fail_count == 0 && n_tests > 0) begin
			$display("Run complete: PASS");
		end else begin
			$display("Run complete: FAIL");
		end
		$finish;
	endtask
	// ----------------------------------------
	// Main sequence
	// ----------------------------------------
	initial begin
		repeat (20) @(posedge mclk);
		#1;
		rst = 1'b0;
		i_bus_master_model.tick(4);
		// Byte write, block bit set, then immediate polling
		cmd(8'hA6, 1'b1);
		send(8'h12);
		send(8'h7E);
		send(8'h55);
		i_bus_master_model.stop_cond();
		check(ptr, 17'h1127F);
		wait_busy(1'b1);
		cmd(8'hA6, 1'b0);
		i_bus_master_model.stop_cond();
		wait_busy(1'b0);
		check(nwr, 128);
		check(getm(17'h1127E), 8'h55);
		check(getm(17'h11200), 8'h3C);
		cmd(8'hA0, 1'b0);
		i_bus_master_model.stop_cond();
		check(ptr, 17'h1127F);
		cmd(8'hA6, 1'b1);
		i_bus_master_model.stop_cond();
		// Page write of 130 bytes across the page end
		nwr = 0;
		cmd(8'hA4, 1'b1);
		send(8'h03);
		send(8'h7E);
		for (int k = 0; k < 130; k++) send(k[7:0]);
		i_bus_master_model.stop_cond();
		wp = 1'b1;
		check(ptr, 17'h00300);
		wait_busy(1'b1);
		wait_busy(1'b0);
		check(nwr, 128);
		for (int o = 0; o < 128; o++) begin
			check(getm(17'h00300 + o), (o > 125) ? o + 2 : o + 2);
		end
		// Protected write: acked, no cycle, ready at once
		nwr = 0;
		cmd(8'hA4, 1'b1);
		send(8'h00);
		send(8'h05);
		send(8'h77);
		i_bus_master_model.stop_cond();
		i_bus_master_model.tick(20);
		check(busy, 1'b0);
		check(nwr, 0);
		cmd(8'hA4, 1'b1);
		i_bus_master_model.stop_cond();
		results();
	end
endmodule
`default_nettype wire
